// ---- rtl/resolver_port_defines.svh ----
// constants and field layout of the resolver host port
//
// How it works
// - reads, writes and serial frames only while chip select is low
// - serial port when select low, else parallel
// - parallel outputs driven only during select and read
// - parallel write bytes taken during select and write
// - frame strobe frames serial transfer, enables msb pin
// - sample falling edge copies position and velocity
// - same sample edge refreshes fault register
// - msb pin is serial out, shifts on rising
// - resolution taken from two resolution select inputs
// - serial input bits captured on falling serial clock
// - operating mode taken from two mode select inputs
`ifndef RESOLVER_PORT_DEFINES_SVH
`define RESOLVER_PORT_DEFINES_SVH

// ***************************************
// widths and field positions
// ***************************************
`define RP_WORD_W      16
`define RP_BYTE_W      8
`define RP_FAULT_W     8
`define RP_SERIAL_LEN  24
`define RP_SERIAL_MSB  23
`define RP_MSB_BIT     15
`define RP_FIFO_DEPTH  16

// ***************************************
// reset values and masks
// ***************************************
`define RP_WORD_RESET  16'h0000
`define RP_FAULT_RESET 8'h00
`define RP_OE_NONE     16'h0000
`define RP_OE_ALL      16'hffff
`define RP_OE_MSB      16'h8000
`define RP_MASK_10     16'hffc0
`define RP_MASK_12     16'hfff0
`define RP_MASK_14     16'hfffc
`define RP_MASK_16     16'hffff
`define RP_LAST_BIT    3'h7

`endif

// ---- rtl/resolver_port_pkg.sv ----
// types shared by the resolver host port
package resolver_port_pkg;

	// ***************************************
	// pin group, sampled together
	// ***************************************
	typedef struct packed {
		logic       chipSelectN;
		logic       readStrobeN;
		logic       writeFrameStrobeN;
		logic       serialPortSelectN;
		logic       sampleStrobe;
		logic       serialClock;
		logic       serialDataIn;
		logic       modeSelectHi;
		logic       modeSelectLo;
		logic       resolutionSelectHi;
		logic       resolutionSelectLo;
		logic [7:0] writeData;
	} hostPins_t;

	// integrator values and faults, live or held
	typedef struct packed {
		logic [15:0] position;
		logic [15:0] velocity;
		logic [7:0]  faults;
	} snapshot_t;

	typedef enum logic [1:0] {
		MODE_POSITION = 2'b00,
		MODE_RESERVED = 2'b01,
		MODE_VELOCITY = 2'b10,
		MODE_CONFIG   = 2'b11
	} portMode_t;

	typedef enum logic {
		FRAME_IDLE   = 1'b0,
		FRAME_ACTIVE = 1'b1
	} frameState_t;

endpackage

// ---- rtl/sample_fifo.sv ----
// small synchronous fifo for bytes written by the host
`timescale 1ns/1ns
`default_nettype none

module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	// pointers need a power of two to wrap cleanly
	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
			$error("sample_fifo: DEPTH must be a power of two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr;
	logic [AW:0]      rdPtr;
	logic             doWrite;
	logic             doRead;

	// full when pointers differ only in the wrap bit
	assign inReady  = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
	assign outValid = wrPtr != rdPtr;
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;
	assign outData  = mem[rdPtr[AW-1:0]];

	// storage, no reset needed on data
	always_ff @(posedge clk) begin
		if (doWrite) begin
			mem[wrPtr[AW-1:0]] <= inData;
		end
	end

	// pointer updates
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr <= '0;
			rdPtr <= '0;
		end else begin
			if (doWrite) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (doRead) begin
				rdPtr <= rdPtr + 1'b1;
			end
		end
	end

endmodule // sample_fifo

`default_nettype wire

// ---- rtl/resolver_host_port_select.sv ----
// host pin logic: parallel and serial ports, sample snapshot
`timescale 1ns/1ns
`default_nettype none
`include "resolver_port_defines.svh"

module resolver_host_port_select #(
	parameter int FIFO_DEPTH = `RP_FIFO_DEPTH
) (
	input  wire logic                           clk,
	input  wire logic                           rst,
	input  wire resolver_port_pkg::hostPins_t   hostPins,
	input  wire resolver_port_pkg::snapshot_t   integrators,
	output logic      [15:0]                    dataOut,
	output logic      [15:0]                    dataOe,
	output logic      [1:0]                     resolution,
	output var  resolver_port_pkg::portMode_t   portMode,
	output logic                                hostWriteReady,
	output logic                                writeValid,
	input  wire logic                           writeReady,
	output logic      [7:0]                     writeByte
);
	import resolver_port_pkg::*;

	// ***************************************
	// pin synchronisers and edge finding
	// ***************************************
	hostPins_t   pinMeta;
	hostPins_t   pins;
	hostPins_t   pinsPrev;
	snapshot_t   snap;
	frameState_t state;
	logic [23:0] shiftReg;
	logic [7:0]  inShift;
	logic [2:0]  inCount;
	logic [7:0]  writeHold;
	logic        pushValid;
	logic [7:0]  pushByte;
	logic [15:0] readWord;
	logic        selected;
	logic        parallelMode;
	logic        serialMode;
	logic        sampleFall;
	logic        sclkRise;
	logic        sclkFall;
	logic        frameOpen;
	logic        frameStart;
	logic        writeOpen;
	logic        parallelPush;
	logic        serialPush;

	// serial frame is open while selected and strobed
	function automatic logic frameActive(hostPins_t p);
		frameActive = !p.serialPortSelectN && !p.chipSelectN &&
			!p.writeFrameStrobeN;
	endfunction

	// parallel write window
	function automatic logic writeWindow(hostPins_t p);
		writeWindow = p.serialPortSelectN && !p.chipSelectN &&
			!p.writeFrameStrobeN;
	endfunction

	// resolution keeps the top bits, lower bits read zero
	function automatic logic [15:0] resolutionMask(logic [1:0] r);
		case (r)
			2'h0:    resolutionMask = `RP_MASK_10;
			2'h1:    resolutionMask = `RP_MASK_12;
			2'h2:    resolutionMask = `RP_MASK_14;
			default: resolutionMask = `RP_MASK_16;
		endcase
	endfunction

	// two synchroniser flops per pin plus pinsPrev for edges; pinMeta is read by pins only
	always_ff @(posedge clk) begin
		pinMeta  <= hostPins;
		pins     <= pinMeta;
		pinsPrev <= pins;
	end

	assign selected     = !pins.chipSelectN;
	assign parallelMode = pins.serialPortSelectN;
	assign serialMode   = !pins.serialPortSelectN;
	assign sampleFall   = pinsPrev.sampleStrobe && !pins.sampleStrobe;
	assign sclkRise     = !pinsPrev.serialClock && pins.serialClock;
	assign sclkFall     = pinsPrev.serialClock && !pins.serialClock;
	assign frameOpen    = frameActive(pins);
	assign frameStart   = frameOpen && !frameActive(pinsPrev);
	assign writeOpen    = writeWindow(pins);
	assign parallelPush = writeWindow(pinsPrev) && !writeOpen;

	// ***************************************
	// sample snapshot and configuration
	// ***************************************
	// whole struct copied in one edge so the host never sees a mix
	always_ff @(posedge clk) begin
		if (rst) begin
			snap.position <= `RP_WORD_RESET;
			snap.velocity <= `RP_WORD_RESET;
			snap.faults   <= `RP_FAULT_RESET;
		end else if (sampleFall) begin
			snap <= integrators;
		end
	end

	// resolution and mode follow their pins
	always_ff @(posedge clk) begin
		if (rst) begin
			resolution <= 2'h3;
			portMode   <= MODE_POSITION;
		end else begin
			resolution <= {pins.resolutionSelectHi,
				pins.resolutionSelectLo};
			portMode   <= portMode_t'({pins.modeSelectHi,
				pins.modeSelectLo});
		end
	end

	// word offered to the host for the current mode
	always_comb begin
		case (portMode)
			MODE_POSITION: readWord = snap.position & resolutionMask(resolution);
			MODE_VELOCITY: readWord = snap.velocity & resolutionMask(resolution);
			default:       readWord = {8'h00, snap.faults};
		endcase
	end

	// ***************************************
	// output buffers
	// ***************************************
	// read strobe is ignored in serial mode, host keeps it high
	always_comb begin
		if (!selected) begin
			dataOe = `RP_OE_NONE;
		end else if (parallelMode && !pins.readStrobeN) begin
			dataOe = `RP_OE_ALL;
		end else if (frameOpen) begin
			dataOe = `RP_OE_MSB;
		end else begin
			dataOe = `RP_OE_NONE;
		end
	end

	// serial bit lags the shift register by one clock
	always_ff @(posedge clk) begin
		if (rst) begin
			dataOut <= `RP_WORD_RESET;
		end else if (parallelMode) begin
			dataOut <= readWord;
		end else begin
			dataOut <= {shiftReg[`RP_SERIAL_MSB], 15'h0000};
		end
	end

	// ***************************************
	// serial frame
	// ***************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= FRAME_IDLE;
		end else begin
			case (state)
				FRAME_IDLE: begin
					if (frameStart) begin
						state <= FRAME_ACTIVE;
					end
				end
				FRAME_ACTIVE: begin
					if (!frameOpen) begin
						state <= FRAME_IDLE;
					end
				end
				default: state <= FRAME_IDLE;
			endcase
		end
	end

	// 16 data bits then 8 fault bits, msb first
	always_ff @(posedge clk) begin
		if (rst) begin
			shiftReg <= '0;
		end else if (frameStart) begin
			shiftReg <= {readWord, snap.faults};
		end else if (state == FRAME_ACTIVE && frameOpen && sclkRise) begin
			shiftReg <= {shiftReg[22:0], 1'b0};
		end
	end

	// input bits gathered into bytes on falling serial clock
	always_ff @(posedge clk) begin
		if (rst) begin
			inShift <= '0;
			inCount <= '0;
		end else if (frameStart) begin
			inCount <= '0;
		end else if (state == FRAME_ACTIVE && frameOpen && sclkFall) begin
			inShift <= {inShift[6:0], pins.serialDataIn};
			inCount <= inCount + 1'b1;
		end
	end

	assign serialPush = state == FRAME_ACTIVE && frameOpen && sclkFall &&
		inCount == `RP_LAST_BIT;

	// ***************************************
	// write path into the fifo
	// ***************************************
	// data held while the window is open, pushed as it closes
	always_ff @(posedge clk) begin
		if (rst) begin
			writeHold <= '0;
		end else if (writeOpen) begin
			writeHold <= pins.writeData;
		end
	end

	// a byte arriving while the fifo is full is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			pushValid <= 1'b0;
			pushByte  <= '0;
		end else begin
			pushValid <= parallelPush || serialPush;
			if (parallelPush) begin
				pushByte <= writeHold;
			end else if (serialPush) begin
				pushByte <= {inShift[6:0], pins.serialDataIn};
			end
		end
	end

	sample_fifo #(
		.WIDTH (`RP_BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk      (clk),
		.rst      (rst),
		.inValid  (pushValid),
		.inReady  (hostWriteReady),
		.inData   (pushByte),
		.outValid (writeValid),
		.outReady (writeReady),
		.outData  (writeByte)
	);

	// ***************************************
	// checks
	// ***************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_CS_GATES_OUTPUTS: assert property (
		pins.chipSelectN |-> dataOe == `RP_OE_NONE)
		else $error("outputs enabled without chip select");
	AST_PARALLEL_DRIVE: assert property (
		parallelMode && selected && !pins.readStrobeN |->
		dataOe == `RP_OE_ALL ##1 dataOut == $past(readWord))
		else $error("parallel read not driven");
	AST_SERIAL_MSB_ONLY: assert property (
		serialMode |-> dataOe[14:0] == 15'h0000)
		else $error("serial mode drives parallel lines");
	AST_SERIAL_FRAME_OE: assert property (
		serialMode |-> dataOe[`RP_MSB_BIT] == frameOpen)
		else $error("serial output enable not tied to frame");
	AST_SAMPLE_COPY: assert property (
		sampleFall |=> snap.position == $past(integrators.position) &&
		snap.velocity == $past(integrators.velocity))
		else $error("sample edge did not copy integrators");
	AST_FAULT_COPY: assert property (
		!sampleFall |=> $stable(snap.faults))
		else $error("fault register changed without sample edge");
	AST_SHIFT_ON_RISE: assert property (
		state == FRAME_ACTIVE && frameOpen && sclkRise && !frameStart
		|=> shiftReg == ($past(shiftReg) << 1))
		else $error("serial data not shifted on rising clock");
	AST_CAPTURE_ON_FALL: assert property (
		state == FRAME_ACTIVE && frameOpen && sclkFall |=>
		inShift[0] == $past(pins.serialDataIn))
		else $error("serial input not captured on falling clock");
	AST_PARALLEL_PUSH: assert property (
		parallelPush |=> pushValid && pushByte == $past(writeHold))
		else $error("parallel write byte not pushed");
	AST_RES_FOLLOWS: assert property (
		!rst |=> resolution == $past({pins.resolutionSelectHi,
		pins.resolutionSelectLo}))
		else $error("resolution not taken from select inputs");

	COV_SAMPLE: cover property (sampleFall);
	COV_SERIAL_BYTE: cover property (serialPush);
	COV_PARALLEL_WRITE: cover property (parallelPush ##1 pushValid);
	COV_FIFO_FULL: cover property (!hostWriteReady);

endmodule // resolver_host_port_select

`default_nettype wire

// ---- testbench/host_serial_model.sv ----
// host side of the serial link: frame clock, data in, data back
`timescale 1ns/1ns
`default_nettype none

module host_serial_model (
	input  wire logic        start,
	input  wire logic [23:0] txBits,
	input  wire logic        sdo,
	output logic             sclk,
	output logic             sdi,
	output logic [23:0]      rxBits,
	output logic             done
);
	// ***************************************
	// frame engine
	// ***************************************
	// clock only runs inside a frame, phase unrelated to the core clock
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		rxBits = '0;
		done = 1'b0;
		forever begin
			@(posedge start);
			done = 1'b0;
			#7;
			for (int i = 23; i >= 0; i--) begin
				#160;
				rxBits[i] = sdo;
				sclk = 1'b1;
				sdi = txBits[i];
				#160;
				sclk = 1'b0;
			end
			// hold past the last fall so it is not seen moving with it
			#160;
			sdi = ~sdi;
			done = 1'b1;
		end
	end
endmodule // host_serial_model
`default_nettype wire

// ---- testbench/resolver_host_port_select_test.sv ----
// self-checking bench for the resolver host port
`timescale 1ns/1ns
`default_nettype none
`include "resolver_port_defines.svh"

module resolver_host_port_select_test;
	import resolver_port_pkg::*;

	// ***************************************
	// signals and instances
	// ***************************************
	logic        clk;
	logic        rst;
	hostPins_t   pins;
	hostPins_t   pinsIn;
	snapshot_t   integ;
	logic [15:0] dataOut;
	logic [15:0] dataOe;
	logic [1:0]  resolution;
	portMode_t   portMode;
	logic        hostWriteReady;
	logic        writeValid;
	logic        writeReady;
	logic [7:0]  writeByte;
	logic        sclk;
	logic        sdi;
	logic        sdoWire;
	logic        start;
	logic [23:0] rxBits;
	logic        done;
	int          fail_count;
	int          tests_run;
	logic [15:0] masks [4] = '{`RP_MASK_10, `RP_MASK_12, `RP_MASK_14,
		`RP_MASK_16};

	// link pins come from the host model, the rest from the bench
	always_comb begin
		pinsIn = pins;
		pinsIn.serialClock = sclk;
		pinsIn.serialDataIn = sdi;
	end
	assign sdoWire = dataOe[15] ? dataOut[15] : 1'bz;

	resolver_host_port_select #(.FIFO_DEPTH(16)) i_dut (
		.clk(clk), .rst(rst), .hostPins(pinsIn), .integrators(integ),
		.dataOut(dataOut), .dataOe(dataOe), .resolution(resolution),
		.portMode(portMode), .hostWriteReady(hostWriteReady),
		.writeValid(writeValid), .writeReady(writeReady),
		.writeByte(writeByte));

	host_serial_model i_host (
		.start(start), .txBits(24'h3cc35a), .sdo(sdoWire), .sclk(sclk),
		.sdi(sdi), .rxBits(rxBits), .done(done));

	// free-running core clock; converter clock range is a board matter
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ***************************************
	// access tasks
	// ***************************************
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// parallel read, strobes held until the word has settled
	task automatic readWord(input logic [15:0] exp);
		@(posedge clk);
		pins.chipSelectN <= 1'b0;
		pins.readStrobeN <= 1'b0;
		step(4);
		check(dataOe, 16'hffff);
		check(dataOut, exp);
		@(posedge clk);
		pins.chipSelectN <= 1'b1;
		pins.readStrobeN <= 1'b1;
		step(4);
		check(dataOe, 16'h0000);
	endtask

	// one write window; data lines change once the window closes
	task automatic writeWin(input logic [7:0] b, input logic csN);
		@(posedge clk);
		pins.chipSelectN <= csN;
		pins.writeFrameStrobeN <= 1'b0;
		pins.writeData <= b;
		step(4);
		check(dataOe, 16'h0000);
		@(posedge clk);
		pins.chipSelectN <= 1'b1;
		pins.writeFrameStrobeN <= 1'b1;
		pins.writeData <= ~b;
		step(4);
	endtask

	task automatic drain(input logic [7:0] exp);
		int i;
		i = 0;
		while (writeValid !== 1'b1 && i < 20) begin
			step(1);
			i++;
		end
		check({writeValid, writeByte}, {1'b1, exp});
		@(posedge clk);
		writeReady <= 1'b1;
		@(posedge clk);
		writeReady <= 1'b0;
		#1;
	endtask

	task automatic sample(input snapshot_t now, input snapshot_t later);
		@(posedge clk);
		integ <= now;
		pins.sampleStrobe <= 1'b0;
		step(4);
		@(posedge clk);
		pins.sampleStrobe <= 1'b1;
		step(4);
		@(posedge clk);
		integ <= later;
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ***************************************
	// test sequence
	// ***************************************
	// pins idle: selects and strobes high, parallel port chosen
	initial begin
		rst = 1'b1;
		writeReady = 1'b0;
		start = 1'b0;
		fail_count = 0;
		tests_run = 0;
		integ = '0;
		pins = 19'h7c000;
		step(10);
		check({resolution, portMode}, {2'b11, 2'b00});
		check(dataOut, 16'h0000);
		check({writeValid, hostWriteReady}, {1'b0, 1'b1});
		@(posedge clk);
		rst <= 1'b0;
		pins.readStrobeN <= 1'b0;
		step(4);
		check(dataOe, 16'h0000);
		$display("test select done");
		sample('{16'ha5c3, 16'h1234, 8'h5a}, '{16'h0f0f, 16'h7777, 8'h11});
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			{pins.resolutionSelectHi, pins.resolutionSelectLo} <= r[1:0];
			pins.readStrobeN <= 1'b1;
			step(4);
			check(resolution, r[1:0]);
			readWord(16'ha5c3 & masks[r]);
		end
		@(posedge clk);
		{pins.modeSelectHi, pins.modeSelectLo} <= 2'b10;
		step(4);
		check(portMode, 2'b10);
		readWord(16'h1234);
		@(posedge clk);
		{pins.modeSelectHi, pins.modeSelectLo} <= 2'b11;
		step(4);
		readWord(16'h005a);
		@(posedge clk);
		{pins.modeSelectHi, pins.modeSelectLo} <= 2'b01;
		step(4);
		check(portMode, 2'b01);
		readWord(16'h005a);
		@(posedge clk);
		{pins.modeSelectHi, pins.modeSelectLo} <= 2'b00;
		$display("test sample done");
		// fill past depth with the drain side stalled
		writeWin(8'hee, 1'b1);
		for (int i = 0; i < 17; i++)
			writeWin(8'h40 + i[7:0], 1'b0);
		check(hostWriteReady, 1'b0);
		for (int i = 0; i < 16; i++)
			drain(8'h40 + i[7:0]);
		step(4);
		check(writeValid, 1'b0);
		$display("test fifo done");
		sample('{16'h0f0f, 16'h7777, 8'h11}, '{16'h5555, 16'h6666, 8'h22});
		@(posedge clk);
		pins.serialPortSelectN <= 1'b0;
		pins.chipSelectN <= 1'b0;
		pins.writeFrameStrobeN <= 1'b0;
		step(4);
		check(dataOe, 16'h8000);
		start <= 1'b1;
		for (int i = 0; i < 400 && done !== 1'b1; i++)
			step(1);
		check(rxBits, {16'h0f0f, 8'h11});
		@(posedge clk);
		pins.chipSelectN <= 1'b1;
		pins.writeFrameStrobeN <= 1'b1;
		start <= 1'b0;
		step(4);
		check(dataOe, 16'h0000);
		drain(8'h3c);
		drain(8'hc3);
		drain(8'h5a);
		$display("test serial done");
		stop_test();
	end

	// hang guard, well beyond the roughly 600 cycles needed
	initial begin
		#200000;
		fail_count++;
		stop_test();
	end
endmodule // resolver_host_port_select_test
`default_nettype wire
